// ---- bench/redundant_ref_clock_switchover_bench.sv ----
// Purpose: self-checking bench for the reference switchover
// Assumes: sources model drives the clock lines
// Notes: expected status worked out by model
`timescale 1ns/1ps
module redundant_ref_clock_switchover_bench;
	import ref_switch_pkg::*;
	logic clk = 1'b0, rst = 1'b1, stop0 = 1'b0, stop1 = 1'b0, clk_out, loop_ref;
	ctrl_t c = 5'h0E;
	ref_lines_t lines;
	status_t st;
	int err_count = 0, n_compared = 0, seed = 83328, e0, e1, ea;
	logic q[$];
	initial forever #50 clk = ~clk;
	ref_sources src (.clk(clk), .stop0(stop0), .stop1(stop1), .lines(lines));
	redundant_ref_clock_switchover dut (.clk(clk), .rst(rst), .lines(lines), .ctrl(c),
		.status(st), .loop_ref(loop_ref), .clk_out(clk_out));
	task automatic summarize();
		$display("compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_status(input logic [2:0] want, input string what, input int limit);
		int i;
		for (i = 0; i < limit && st[3:1] !== want; i++) tick(1);
		n_compared++;
		if (st[3:1] !== want) begin
			$display("unexpected %s: expected %b seen %b", what, want, st[3:1]);
			err_count++;
			summarize();
		end
	endtask
	task automatic step(input string what);
		tick(6);
		e0 = stop0;
		e1 = stop1;
		if (c.manual_force || !(stop0 || stop1)) ea = c.primary_sel;
		else if (stop0 && stop1) ea = 0;
		else ea = stop0;
		wait_status({e0[0], e1[0], ea[0]}, what, 300);
	endtask
	task automatic clear();
		@(posedge clk) c.alarm_clear_n <= 1'b0;
		@(posedge clk) c.alarm_clear_n <= 1'b1;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		tick(10);
		n_compared++;
		if (clk_out !== 1'b0) begin
			$display("unexpected clk_out: expected 0 seen %b", clk_out);
			err_count++;
		end
		@(posedge clk) c.master_reset_n <= 1'b1;
		clear();
		repeat (4) begin
			@(posedge clk) c.primary_sel <= 1'($random(seed));
			step("select");
		end
		// bypass: output and loop reference show the selected input three edges late
		@(posedge clk) c.bypass_n <= 1'b0;
		tick(4);
		for (int k = 0; k < 12; k++) begin
			tick(1);
			q.push_back(ea[0] ? lines.ref1 : lines.ref0);
			if (k > 2) begin
				n_compared++;
				if (clk_out !== q[k - 3] || loop_ref !== q[k - 3]) begin
					$display("unexpected bypass: expected %b seen %b %b", q[k - 3], clk_out,
						loop_ref);
					err_count++;
				end
			end
		end
		@(posedge clk) c.bypass_n <= 1'b1;
		@(posedge clk) c.primary_sel <= 1'b0;
		stop0 <= 1'b1;
		step("forced fault");
		@(posedge clk) stop0 <= 1'b0;
		clear();
		step("clear");
		@(posedge clk) c.manual_force <= 1'b0;
		stop0 <= 1'b1;
		step("failover");
		@(posedge clk) c.primary_sel <= 1'b1;
		step("hold");
		@(posedge clk) c.primary_sel <= 1'b0;
		repeat (12) begin
			tick(1);
			wait_status(3'h5, "held selection", 0);
		end
		@(posedge clk) stop1 <= 1'b1;
		wait_status(3'h7, "second fault", 300);
		@(posedge clk) c.primary_sel <= 1'b0;
		{stop0, stop1} <= 2'h0;
		clear();
		step("release");
		@(posedge clk) c.primary_sel <= 1'b1;
		{stop0, stop1} <= 2'h3;
		step("both bad");
		clear();
		wait_status({2'h0, c.primary_sel}, "clear window", 300);
		step("both bad again");
		summarize();
	end
endmodule
bind redundant_ref_clock_switchover redundant_ref_clock_switchover_props props (.clk(clk),
	.rst(rst), .lines(lines), .ctrl(ctrl), .status(status), .loop_ref(loop_ref),
	.clk_out(clk_out));

// ---- bench/redundant_ref_clock_switchover_props.sv ----
// Purpose: port assertions for the reference switchover
// Assumes: one clock, synchronous reset
// Notes: none
`timescale 1ns/1ps
module redundant_ref_clock_switchover_props
	import ref_switch_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched ports
	input wire ref_lines_t lines,
	input wire ctrl_t ctrl,
	input wire status_t status,
	input wire logic loop_ref,
	input wire logic clk_out
);
	logic [3:0] clr_age, quiet0;
	logic f0, f1;
	assign f0 = status.input0_fault_flag;
	assign f1 = status.input1_fault_flag;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// cycles since the last clear edge and since reference 0 last moved
	always_ff @(posedge clk) begin
		if (rst) clr_age <= 4'hF;
		else if ($fell(ctrl.alarm_clear_n)) clr_age <= 4'h0;
		else if (clr_age != 4'hF) clr_age <= clr_age + 4'h1;
		if (rst || $changed(lines.ref0)) quiet0 <= 4'h0;
		else if (quiet0 != 4'hF) quiet0 <= quiet0 + 4'h1;
	end
	flag_clear_a: assert property ($fell(f0) || $fell(f1) |-> clr_age inside {[4'h2:4'h6]})
		else $error("fault flag fell without a clear edge");
	mreset_low_a: assert property ((!ctrl.master_reset_n)[*6] |-> !clk_out)
		else $error("output clock runs under master reset");
	follow_sel_a: assert property ((!f0 && !f1 && $stable(ctrl.primary_sel))[*6]
		|-> status.active_ref == ctrl.primary_sel) else $error("selection ignores select pin");
	force_sel_a: assert property ((ctrl.manual_force && $stable(ctrl.primary_sel))[*6]
		|-> status.active_ref == ctrl.primary_sel) else $error("forced selection wrong");
	fail_over_a: assert property ((!ctrl.manual_force)[*6] ##0 ($rose(f0) && !f1)
		|-> ##[0:2] status.active_ref) else $error("no switch to input 1");
	both_bad_a: assert property ((!ctrl.manual_force)[*6] ##0 ($rose(f0) && $rose(f1))
		|-> ##[0:2] !status.active_ref) else $error("both bad not on input 0");
	hold_ref_a: assert property ((!ctrl.manual_force && (f0 || f1) && $stable({f0, f1}))[*6]
		|-> $stable(status.active_ref)) else $error("latched selection moved");
	stuck_age_a: assert property ($rose(f0) |-> quiet0 >= 4'h4)
		else $error("fault flagged on a live input");
	realign_start_a: assert property ($changed(status.active_ref) |-> status.realign)
		else $error("switch without realignment");
	realign_end_a: assert property ($fell(status.realign) |-> $rose(loop_ref))
		else $error("realignment ended off a rising edge");
	bypass_path_a: assert property ((!ctrl.bypass_n && ctrl.master_reset_n)[*4]
		|-> clk_out == loop_ref) else $error("bypass does not pass the reference");
	divider_run_a: assert property ((ctrl.bypass_n && ctrl.master_reset_n)[*5]
		|-> clk_out != $past(clk_out)) else $error("output divider stalled");
endmodule

// ---- bench/ref_sources.sv ----
// Purpose: two reference clocks and a feedback clock
// Assumes: references period 4 cycles, feedback period 8
// Notes: a stopped reference freezes at its level
`timescale 1ns/1ps
module ref_sources
	import ref_switch_pkg::*;
(
	// clock
	input wire logic clk,
	// fault injection
	input wire logic stop0,
	input wire logic stop1,
	// clock lines
	output ref_lines_t lines
);
	logic [2:0] cnt = 3'h0;
	initial lines = 3'h0;
	always @(posedge clk) begin
		cnt <= cnt + 3'h1;
		if (!stop0) lines.ref0 <= cnt[1];
		if (!stop1) lines.ref1 <= cnt[1];
		lines.fb <= cnt[2];
	end
endmodule

// ---- common/ref_switch_pkg.sv ----
// Purpose: shared constants and carrier types for the reference switchover block
// Assumes: one 10 MHz system clock; reference and feedback clocks arrive as sampled levels
// Notes: none
package ref_switch_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SYNC_STAGES = 2;
	localparam logic SEL_INPUT0 = 1'b0;
	localparam logic SEL_INPUT1 = 1'b1;
	// a feedback period is counted edge to like edge, so two like edges with no input change
	localparam logic [1:0] STUCK_EDGES = 2'h2;
	localparam logic [1:0] EDGE_CNT_ZERO = 2'h0;
	localparam logic [1:0] EDGE_CNT_ONE = 2'h1;
	localparam logic [2:0] DIV_ZERO = 3'h0;
	localparam logic [2:0] DIV_ONE = 3'h1;

	typedef struct packed {
		logic ref0;
		logic ref1;
		logic fb;
	} ref_lines_t;

	typedef struct packed {
		logic primary_sel;
		logic manual_force;
		logic alarm_clear_n;
		logic bypass_n;
		logic master_reset_n;
	} ctrl_t;

	typedef struct packed {
		logic input0_fault_flag;
		logic input1_fault_flag;
		logic active_ref;
		logic realign;
	} status_t;

	typedef enum logic [2:0] {
		ALIGN_IDLE = 3'h1,
		ALIGN_WAIT_FALL = 3'h2,
		ALIGN_WAIT_RISE = 3'h4
	} align_state_t;
endpackage

// ---- design/redundant_ref_clock_switchover.sv ----
// Purpose: fault monitoring and reference selection for a redundant reference clock loop
// Assumes: reference and control pins asynchronous to clk and sampled through two flip-flops; rst synchronous
// Notes: divider models a divide-by-two output clock gated by master reset
`timescale 1ns/1ps
// Function
// - active_ref low for input0, high for input1
// - latch fault after one stuck feedback period
// - fault flags clear only on alarm clear
// - primary_sel picks primary input
// - alarm clear falling edge makes one-shot pulse
// - bypass low passes selected reference through
// - master reset low holds dividers, clk_out low; loop_ref keeps running
// - manual force: reference follows primary select
// - fault detection runs in both force modes
// - automatic: first failure switches to other input
// - latches hold until clear, then follow select
// - both bad after clear: select input0
// - no fault latched: selection follows select pin
// - after switch, wait new fall then rise
module redundant_ref_clock_switchover
	import ref_switch_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// reference and feedback clocks
	input wire ref_lines_t lines,
	// board controls
	input wire ctrl_t ctrl,
	// status pins
	output status_t status,
	// loop reference and output clock
	output logic loop_ref,
	output logic clk_out
);
	logic [SYNC_STAGES-1:0] s_ref0_reg, s_ref1_reg, s_fb_reg;
	logic [SYNC_STAGES-1:0] s_sel_reg, s_force_reg, s_clr_reg, s_byp_reg, s_mr_reg;
	logic [SYNC_STAGES-1:0] s_ref0_next, s_ref1_next, s_fb_next;
	logic [SYNC_STAGES-1:0] s_sel_next, s_force_next, s_clr_next, s_byp_next, s_mr_next;
	logic ref0_s, ref1_s, fb_s, sel_s, force_s, clr_s, byp_s, mr_s;
	logic stuck0, stuck1;
	logic clr_d_reg, clr_d_next;
	logic clear_pulse_reg, clear_pulse_next;
	logic fault0_reg, fault0_next, fault1_reg, fault1_next;
	logic active_reg, active_next;
	align_state_t align_reg, align_next;
	logic sel_ref_d_reg, sel_ref_d_next;
	logic realign_reg, realign_next;
	logic loop_ref_reg, loop_ref_next;
	logic [2:0] div_reg, div_next;
	logic clk_out_reg, clk_out_next;
	logic sel_ref;

	function automatic logic [SYNC_STAGES-1:0] shift_in(input logic [SYNC_STAGES-1:0] s,
		input logic d);
		shift_in = {s[SYNC_STAGES-2:0], d};
	endfunction

	// two flip-flop synchronisers; only the last stage is read
	always_comb begin
		s_ref0_next = shift_in(s_ref0_reg, lines.ref0);
		s_ref1_next = shift_in(s_ref1_reg, lines.ref1);
		s_fb_next = shift_in(s_fb_reg, lines.fb);
		s_sel_next = shift_in(s_sel_reg, ctrl.primary_sel);
		s_force_next = shift_in(s_force_reg, ctrl.manual_force);
		s_clr_next = shift_in(s_clr_reg, ctrl.alarm_clear_n);
		s_byp_next = shift_in(s_byp_reg, ctrl.bypass_n);
		s_mr_next = shift_in(s_mr_reg, ctrl.master_reset_n);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_ref0_reg <= '0;
			s_ref1_reg <= '0;
			s_fb_reg <= '0;
			s_sel_reg <= '0;
			s_force_reg <= '0;
			s_clr_reg <= '1;
			s_byp_reg <= '1;
			s_mr_reg <= '0;
		end else begin
			s_ref0_reg <= s_ref0_next;
			s_ref1_reg <= s_ref1_next;
			s_fb_reg <= s_fb_next;
			s_sel_reg <= s_sel_next;
			s_force_reg <= s_force_next;
			s_clr_reg <= s_clr_next;
			s_byp_reg <= s_byp_next;
			s_mr_reg <= s_mr_next;
		end
	end

	assign ref0_s = s_ref0_reg[SYNC_STAGES-1];
	assign ref1_s = s_ref1_reg[SYNC_STAGES-1];
	assign fb_s = s_fb_reg[SYNC_STAGES-1];
	assign sel_s = s_sel_reg[SYNC_STAGES-1];
	assign force_s = s_force_reg[SYNC_STAGES-1];
	assign clr_s = s_clr_reg[SYNC_STAGES-1];
	assign byp_s = s_byp_reg[SYNC_STAGES-1];
	assign mr_s = s_mr_reg[SYNC_STAGES-1];

	// detectors run whatever the force mode is
	stuck_detector det0 (
		.clk(clk),
		.rst(rst),
		.ref_sync(ref0_s),
		.fb_sync(fb_s),
		// a dead input needs a full feedback period again after a clear
		.restart(clear_pulse_reg),
		.stuck(stuck0)
	);

	stuck_detector det1 (
		.clk(clk),
		.rst(rst),
		.ref_sync(ref1_s),
		.fb_sync(fb_s),
		.restart(clear_pulse_reg),
		.stuck(stuck1)
	);

	// fault latches, selection latch and clear one-shot
	always_comb begin
		clr_d_next = clr_s;
		clear_pulse_next = clr_d_reg && !clr_s;
		fault0_next = fault0_reg;
		fault1_next = fault1_reg;
		active_next = active_reg;
		if (clear_pulse_reg) begin
			fault0_next = 1'b0;
			fault1_next = 1'b0;
			active_next = sel_s;
		end else begin
			if (stuck0)
				fault0_next = 1'b1;
			if (stuck1)
				fault1_next = 1'b1;
			// without manual force, once a flag is latched the selection holds until the clear pulse
			if (force_s)
				active_next = sel_s;
			else if (!fault0_reg && !fault1_reg) begin
				if (fault0_next && fault1_next)
					active_next = SEL_INPUT0;
				else if (fault0_next)
					active_next = SEL_INPUT1;
				else if (fault1_next)
					active_next = SEL_INPUT0;
				else
					active_next = sel_s;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clr_d_reg <= 1'b1;
			clear_pulse_reg <= 1'b0;
			fault0_reg <= 1'b0;
			fault1_reg <= 1'b0;
			active_reg <= SEL_INPUT0;
		end else begin
			clr_d_reg <= clr_d_next;
			clear_pulse_reg <= clear_pulse_next;
			fault0_reg <= fault0_next;
			fault1_reg <= fault1_next;
			active_reg <= active_next;
		end
	end

	assign sel_ref = (active_reg == SEL_INPUT1) ? ref1_s : ref0_s;

	// realignment sequencer after any switch
	always_comb begin
		align_next = align_reg;
		sel_ref_d_next = sel_ref;
		case (align_reg)
			ALIGN_IDLE: begin
				if (active_next != active_reg)
					align_next = ALIGN_WAIT_FALL;
			end
			ALIGN_WAIT_FALL: begin
				if (sel_ref_d_reg && !sel_ref)
					align_next = ALIGN_WAIT_RISE;
			end
			ALIGN_WAIT_RISE: begin
				if (!sel_ref_d_reg && sel_ref)
					align_next = ALIGN_IDLE;
			end
			default: align_next = ALIGN_IDLE;
		endcase
		// a switch in mid realignment restarts the wait for the new falling edge
		if (active_next != active_reg)
			align_next = ALIGN_WAIT_FALL;
		realign_next = (align_next != ALIGN_IDLE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			align_reg <= ALIGN_IDLE;
			sel_ref_d_reg <= 1'b0;
			realign_reg <= 1'b0;
		end else begin
			align_reg <= align_next;
			sel_ref_d_reg <= sel_ref_d_next;
			realign_reg <= realign_next;
		end
	end

	// output divider and bypass path
	always_comb begin
		loop_ref_next = sel_ref;
		div_next = div_reg + DIV_ONE;
		clk_out_next = byp_s ? div_reg[0] : sel_ref;
		if (!mr_s) begin
			div_next = DIV_ZERO;
			clk_out_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			loop_ref_reg <= 1'b0;
			div_reg <= DIV_ZERO;
			clk_out_reg <= 1'b0;
		end else begin
			loop_ref_reg <= loop_ref_next;
			div_reg <= div_next;
			clk_out_reg <= clk_out_next;
		end
	end

	assign status = {fault0_reg, fault1_reg, active_reg, realign_reg};
	assign loop_ref = loop_ref_reg;
	assign clk_out = clk_out_reg;
endmodule

// ---- design/stuck_detector.sv ----
// Purpose: flags a reference input that shows no transition over one feedback period
// Assumes: inputs already synchronised to clk
// Notes: counts feedback rising edges and falling edges without a reference change
`timescale 1ns/1ps
module stuck_detector
	import ref_switch_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sampled lines
	input wire logic ref_sync,
	input wire logic fb_sync,
	// restart of the period count after an alarm clear
	input wire logic restart,
	// result
	output logic stuck
);
	logic ref_d_reg, ref_d_next;
	logic fb_d_reg, fb_d_next;
	logic [1:0] rise_cnt_reg, rise_cnt_next;
	logic [1:0] fall_cnt_reg, fall_cnt_next;
	logic stuck_reg, stuck_next;

	always_comb begin
		ref_d_next = ref_sync;
		fb_d_next = fb_sync;
		rise_cnt_next = rise_cnt_reg;
		fall_cnt_next = fall_cnt_reg;
		if (restart || ref_sync != ref_d_reg) begin
			rise_cnt_next = EDGE_CNT_ZERO;
			fall_cnt_next = EDGE_CNT_ZERO;
		end else begin
			if (fb_sync && !fb_d_reg && rise_cnt_reg != STUCK_EDGES)
				rise_cnt_next = rise_cnt_reg + EDGE_CNT_ONE;
			if (!fb_sync && fb_d_reg && fall_cnt_reg != STUCK_EDGES)
				fall_cnt_next = fall_cnt_reg + EDGE_CNT_ONE;
		end
		stuck_next = (rise_cnt_next == STUCK_EDGES) || (fall_cnt_next == STUCK_EDGES);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ref_d_reg <= 1'b0;
			fb_d_reg <= 1'b0;
			rise_cnt_reg <= EDGE_CNT_ZERO;
			fall_cnt_reg <= EDGE_CNT_ZERO;
			stuck_reg <= 1'b0;
		end else begin
			ref_d_reg <= ref_d_next;
			fb_d_reg <= fb_d_next;
			rise_cnt_reg <= rise_cnt_next;
			fall_cnt_reg <= fall_cnt_next;
			stuck_reg <= stuck_next;
		end
	end

	assign stuck = stuck_reg;
endmodule
